// >>> include/counter_array_pkg.sv
/*
 * Constants, register layout and field structs for the counter array core.
 * Assumes an Avalon-MM master with 32-bit data and byte addresses.
 */
// What this block does
// - counter is 16 bits, read as two bytes
// - low-byte read latches high byte into snapshot
// - byte reads never disturb counting
// - three-bit field selects one of seven timebases; code 7 stops counting
// - external mode counts falling edges, max quarter rate
// - oscillator divided sources synchronised before counting
// - wrap from all ones sets overflow flag
// - overflow flag interrupts only when enabled
// - overflow flag cleared only by software
// - idle does not stop counting unless suspended
// - five event flags feed the interrupt
// - intermediate flag on 8th to 11th bit overflow
// - flags set regardless of interrupt enables
// - each flag has enable; request ORs enabled flags
// - interrupt needs global and array enables
// - three compare/capture modules, each own line
// - each module independently takes six modes
// - module 2 watchdog after reset, restricts writes
package counter_array_pkg;

   localparam int          DATA_W      = 32;
   localparam int          ADDR_W      = 6;
   localparam int          NUM_MODULES = 3;
   localparam int          NUM_MODES   = 6;

   // register byte offsets
   localparam logic [5:0]  OFS_COUNT_LOW  = 6'h00;
   localparam logic [5:0]  OFS_COUNT_HIGH = 6'h04;
   localparam logic [5:0]  OFS_MODE       = 6'h08;
   localparam logic [5:0]  OFS_FLAGS      = 6'h0c;
   localparam logic [5:0]  OFS_ENABLE     = 6'h10;
   localparam logic [5:0]  OFS_GLOBAL     = 6'h14;
   localparam logic [5:0]  OFS_MODULE0    = 6'h18;

   // timebase encodings
   localparam logic [2:0]  TB_DIV12    = 3'h0;
   localparam logic [2:0]  TB_DIV4     = 3'h1;
   localparam logic [2:0]  TB_TIMER0   = 3'h2;
   localparam logic [2:0]  TB_EXT_PIN  = 3'h3;
   localparam logic [2:0]  TB_SYSCLK   = 3'h4;
   localparam logic [2:0]  TB_EXT_OSC  = 3'h5;
   localparam logic [2:0]  TB_RTC_OSC  = 3'h6;

   localparam logic [3:0]  PRESC_LAST  = 4'hb;
   localparam logic [1:0]  DIV4_PHASE  = 2'h3;
   localparam logic [15:0] COUNT_FULL  = 16'hffff;
   localparam int          PIN_SYNC    = 3;

   typedef struct packed {
      logic       idle_suspend;
      logic       watchdog_mode;
      logic [2:0] timebase_select;
      logic       overflow_irq_enable;
   } mode_reg_t;

   typedef struct packed {
      logic       count_overflow_flag;
      logic       intermediate_overflow_flag;
      logic [2:0] module_event_flag;
   } flags_t;

   typedef struct packed {
      logic [1:0] cycle_length;
      logic       intermediate_overflow_enable;
      logic [2:0] module_event_enable;
   } enable_t;

   typedef struct packed {
      logic global_irq_enable;
      logic array_irq_enable;
   } global_t;

   localparam mode_reg_t   MODE_RESET   = '{idle_suspend: 1'b0, watchdog_mode: 1'b1,
                                            timebase_select: 3'h0, overflow_irq_enable: 1'b0};
   localparam flags_t      FLAGS_RESET  = '0;
   localparam enable_t     ENABLE_RESET = '0;
   localparam global_t     GLOBAL_RESET = '0;
   localparam logic [2:0]  MODULE_MODE_RESET = 3'h0;

endpackage

// >>> design/counter_array.sv
/*
 * Counter array core: 16-bit counter with snapshot, timebase selector,
 * event flags and interrupt gating, behind an Avalon-MM slave.
 * Assumes module_event pulses come from same-clock module logic and
 * the three pin inputs are asynchronous.
 */
`timescale 1ns/100ps
module counter_array
   import counter_array_pkg::*;
(
   input  wire logic              core_clk,        // 125 MHz system clock
   input  wire logic              sys_rst,         // async reset, active high
   input  wire logic [ADDR_W-1:0] address,         // byte address
   input  wire logic              read,            // read request
   input  wire logic              write,           // write request
   input  wire logic [DATA_W-1:0] writedata,       // write data
   output logic      [DATA_W-1:0] readdata,        // read data
   output logic                   waitrequest,     // high until answered
   input  wire logic              timer0_overflow, // one-cycle pulse
   input  wire logic              external_count_input, // async pin
   input  wire logic              ext_osc_div8,    // async divided clock
   input  wire logic              rtc_osc_div8,    // async divided clock
   input  wire logic              cpu_idle,        // processor idle state
   input  wire logic [NUM_MODULES-1:0] module_event, // module trigger pulses
   output logic                   array_irq_req,   // OR of enabled flags
   output logic                   cpu_irq          // request seen by processor
);

   logic [15:0]            count_r;
   logic [7:0]             snap_r;
   mode_reg_t              mode_r;
   flags_t                 flags_r;
   enable_t                enable_r;
   global_t                global_r;
   logic [2:0]             module_mode_r [NUM_MODULES];
   logic [3:0]             presc_r;
   logic [PIN_SYNC-1:0]    sync_r [3];
   logic [2:0]             level_r;
   logic                   waitrequest_r;
   logic [DATA_W-1:0]      readdata_r;
   logic                   array_irq_req_r;
   logic                   cpu_irq_r;

   logic                   rd_take;
   logic                   wr_take;
   logic [2:0]             fall;
   logic [2:0]             rise;
   logic                   tick;
   logic                   adv;
   logic                   cnt_wr;
   logic [15:0]            count_nxt;
   logic [DATA_W-1:0]      readdata_nxt;
   flags_t                 flags_nxt;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
      hit = (a[ADDR_W-1:2] == ofs[5:2]);
   endfunction

   function automatic logic low_bits_full(input logic [15:0] c, input logic [1:0] len);
      case (len)
         2'h0:    low_bits_full = &c[7:0];
         2'h1:    low_bits_full = &c[8:0];
         2'h2:    low_bits_full = &c[9:0];
         default: low_bits_full = &c[10:0];
      endcase
   endfunction

   // answer taken one edge after request, write acts on the release edge
   assign rd_take = read && waitrequest_r;
   assign wr_take = write && !waitrequest_r;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         waitrequest_r <= 1'b1;
      end else begin
         waitrequest_r <= !((read || write) && waitrequest_r);
      end
   end

   always_comb begin
      readdata_nxt = '0;
      if (hit(address, OFS_COUNT_LOW)) begin
         readdata_nxt[7:0] = count_r[7:0];
      end else if (hit(address, OFS_COUNT_HIGH)) begin
         readdata_nxt[7:0] = snap_r;
      end else if (hit(address, OFS_MODE)) begin
         readdata_nxt[$bits(mode_reg_t)-1:0] = mode_r;
      end else if (hit(address, OFS_FLAGS)) begin
         readdata_nxt[$bits(flags_t)-1:0] = flags_r;
      end else if (hit(address, OFS_ENABLE)) begin
         readdata_nxt[$bits(enable_t)-1:0] = enable_r;
      end else if (hit(address, OFS_GLOBAL)) begin
         readdata_nxt[$bits(global_t)-1:0] = global_r;
      end else begin
         for (int i = 0; i < NUM_MODULES; i++) begin
            if (hit(address, OFS_MODULE0 + 6'(4 * i))) begin
               readdata_nxt[2:0] = module_mode_r[i];
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         readdata_r <= '0;
      end else if (rd_take) begin
         readdata_r <= readdata_nxt;
      end
   end

   // snapshot of high byte, taken with the low byte read
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         snap_r <= 8'h00;
      end else if (rd_take && hit(address, OFS_COUNT_LOW)) begin
         snap_r <= count_r[15:8];
      end
   end

   // pin synchronisers: change counts once stages two and three agree
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 3; i++) begin
            sync_r[i] <= '0;
         end
         level_r <= 3'h0;
      end else begin
         sync_r[0] <= {sync_r[0][1:0], external_count_input};
         sync_r[1] <= {sync_r[1][1:0], ext_osc_div8};
         sync_r[2] <= {sync_r[2][1:0], rtc_osc_div8};
         for (int i = 0; i < 3; i++) begin
            if (sync_r[i][1] == sync_r[i][2]) begin
               level_r[i] <= sync_r[i][2];
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         fall[i] = level_r[i] && !sync_r[i][1] && !sync_r[i][2];
         rise[i] = !level_r[i] && sync_r[i][1] && sync_r[i][2];
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         presc_r <= 4'h0;
      end else begin
         presc_r <= (presc_r == PRESC_LAST) ? 4'h0 : presc_r + 4'h1;
      end
   end

   always_comb begin
      case (mode_r.timebase_select)
         TB_DIV12:   tick = (presc_r == PRESC_LAST);
         TB_DIV4:    tick = (presc_r[1:0] == DIV4_PHASE);
         TB_TIMER0:  tick = timer0_overflow;
         TB_EXT_PIN: tick = fall[0];
         TB_SYSCLK:  tick = 1'b1;
         TB_EXT_OSC: tick = rise[1];
         TB_RTC_OSC: tick = rise[2];
         default:    tick = 1'b0;
      endcase
   end

   assign adv = tick && !(mode_r.idle_suspend && cpu_idle);

   // counter byte writes are blocked while the watchdog is armed
   assign cnt_wr = wr_take && !mode_r.watchdog_mode &&
                   (hit(address, OFS_COUNT_LOW) || hit(address, OFS_COUNT_HIGH));

   always_comb begin
      count_nxt = count_r;
      if (cnt_wr) begin
         if (hit(address, OFS_COUNT_LOW)) begin
            count_nxt[7:0] = writedata[7:0];
         end else begin
            count_nxt[15:8] = writedata[7:0];
         end
      end else if (adv) begin
         count_nxt = count_r + 16'h0001;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= 16'h0000;
      end else begin
         count_r <= count_nxt;
      end
   end

   // flags: software write, then hardware set wins
   always_comb begin
      flags_nxt = flags_r;
      if (wr_take && hit(address, OFS_FLAGS)) begin
         flags_nxt = flags_t'(writedata[$bits(flags_t)-1:0]);
      end
      if (adv && count_r == COUNT_FULL) begin
         flags_nxt.count_overflow_flag = 1'b1;
      end
      if (adv && low_bits_full(count_r, enable_r.cycle_length)) begin
         flags_nxt.intermediate_overflow_flag = 1'b1;
      end
      flags_nxt.module_event_flag = flags_nxt.module_event_flag | module_event;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flags_r <= FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_r <= MODE_RESET;
      end else if (wr_take && hit(address, OFS_MODE)) begin
         mode_r.watchdog_mode       <= writedata[4];
         mode_r.overflow_irq_enable <= writedata[0];
         if (!mode_r.watchdog_mode) begin
            mode_r.idle_suspend    <= writedata[5];
            mode_r.timebase_select <= writedata[3:1];
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         enable_r <= ENABLE_RESET;
         global_r <= GLOBAL_RESET;
      end else begin
         if (wr_take && hit(address, OFS_ENABLE)) begin
            enable_r <= enable_t'(writedata[$bits(enable_t)-1:0]);
         end
         if (wr_take && hit(address, OFS_GLOBAL)) begin
            global_r <= global_t'(writedata[$bits(global_t)-1:0]);
         end
      end
   end

   // per-module modes; codes past the last mode are ignored
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_MODULES; i++) begin
            module_mode_r[i] <= MODULE_MODE_RESET;
         end
      end else begin
         for (int i = 0; i < NUM_MODULES; i++) begin
            if (wr_take && hit(address, OFS_MODULE0 + 6'(4 * i)) && writedata[2:0] < 3'(NUM_MODES) &&
                !(i == 2 && mode_r.watchdog_mode)) begin
               module_mode_r[i] <= writedata[2:0];
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         array_irq_req_r <= 1'b0;
         cpu_irq_r       <= 1'b0;
      end else begin
         array_irq_req_r <= (flags_r.count_overflow_flag && mode_r.overflow_irq_enable) ||
                            (flags_r.intermediate_overflow_flag &&
                             enable_r.intermediate_overflow_enable) ||
                            |(flags_r.module_event_flag & enable_r.module_event_enable);
         cpu_irq_r       <= array_irq_req_r && global_r.global_irq_enable &&
                            global_r.array_irq_enable;
      end
   end

   assign readdata      = readdata_r;
   assign waitrequest   = waitrequest_r;
   assign array_irq_req = array_irq_req_r;
   assign cpu_irq       = cpu_irq_r;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_snapshot;
      rd_take && hit(address, OFS_COUNT_LOW) |=> snap_r == $past(count_r[15:8]);
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("snapshot not taken");

   property p_advance;
      adv && !cnt_wr |=> count_r == $past(count_r) + 16'h0001;
   endproperty
   a_advance: assert property (p_advance) else $error("counter missed a tick");

   property p_reserved;
      mode_r.timebase_select == 3'h7 && !cnt_wr |=> $stable(count_r);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved timebase advanced");

   property p_wrap;
      adv && !cnt_wr && count_r == COUNT_FULL |=> count_r == 16'h0000 && flags_r.count_overflow_flag;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap did not set overflow flag");

   property p_intermediate;
      adv && enable_r.cycle_length == 2'h0 && count_r[7:0] == 8'hff |=> flags_r.intermediate_overflow_flag;
   endproperty
   a_intermediate: assert property (p_intermediate) else $error("intermediate flag missed");

   property p_idle_runs;
      cpu_idle && !mode_r.idle_suspend && mode_r.timebase_select == TB_SYSCLK && !cnt_wr |=> !$stable(count_r);
   endproperty
   a_idle_runs: assert property (p_idle_runs) else $error("counter stopped in idle");

   property p_ext_fall;
      mode_r.timebase_select == TB_EXT_PIN && !cnt_wr && fall[0] && !(mode_r.idle_suspend && cpu_idle)
         |=> count_r == $past(count_r) + 16'h0001;
   endproperty
   a_ext_fall: assert property (p_ext_fall) else $error("external edge not counted");

   property p_ovf_gate;
      flags_r.count_overflow_flag && !mode_r.overflow_irq_enable && !flags_r.intermediate_overflow_flag &&
         flags_r.module_event_flag == 3'h0 |=> !array_irq_req_r;
   endproperty
   a_ovf_gate: assert property (p_ovf_gate) else $error("disabled overflow raised request");

   property p_cpu_gate;
      cpu_irq_r |-> $past(global_r.global_irq_enable) && $past(global_r.array_irq_enable) &&
                    $past(array_irq_req_r);
   endproperty
   a_cpu_gate: assert property (p_cpu_gate) else $error("processor request without enables");

   property p_wd_lock;
      wr_take && hit(address, OFS_MODE) && mode_r.watchdog_mode |=> $stable(mode_r.timebase_select);
   endproperty
   a_wd_lock: assert property (p_wd_lock) else $error("timebase changed in watchdog mode");

   property p_flag_hold;
      flags_r.count_overflow_flag && !(wr_take && hit(address, OFS_FLAGS)) |=> flags_r.count_overflow_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("overflow flag cleared by hardware");

   property p_event_set;
      module_event != 3'h0 |=> (flags_r.module_event_flag & $past(module_event)) == $past(module_event);
   endproperty
   a_event_set: assert property (p_event_set) else $error("module event flag not set");

   property p_irq_module;
      |(flags_r.module_event_flag & enable_r.module_event_enable) |=> array_irq_req_r;
   endproperty
   a_irq_module: assert property (p_irq_module) else $error("enabled module flag gave no request");

   property p_osc_rise;
      mode_r.timebase_select == TB_EXT_OSC && rise[1] && !cnt_wr && !(mode_r.idle_suspend && cpu_idle)
         |=> count_r == $past(count_r) + 16'h0001;
   endproperty
   a_osc_rise: assert property (p_osc_rise) else $error("oscillator edge not counted");

   property p_rtc_rise;
      mode_r.timebase_select == TB_RTC_OSC && rise[2] && !cnt_wr && !(mode_r.idle_suspend && cpu_idle)
         |=> count_r == $past(count_r) + 16'h0001;
   endproperty
   a_rtc_rise: assert property (p_rtc_rise) else $error("clock oscillator edge not counted");

   property p_answer_once;
      !waitrequest_r |=> waitrequest_r;
   endproperty
   a_answer_once: assert property (p_answer_once) else $error("waitrequest low for more than one cycle");

   property p_wd_module2;
      wr_take && hit(address, OFS_MODULE0 + 6'h08) && mode_r.watchdog_mode |=> $stable(module_mode_r[2]);
   endproperty
   a_wd_module2: assert property (p_wd_module2) else $error("module 2 mode changed in watchdog mode");

   c_overflow: cover property (adv && count_r == COUNT_FULL ##1 flags_r.count_overflow_flag);
   c_cpu_irq:  cover property ($rose(cpu_irq_r));
   c_ext_tick: cover property (mode_r.timebase_select == TB_EXT_PIN && fall[0]);
   c_wd_write: cover property (wr_take && hit(address, OFS_MODE) && mode_r.watchdog_mode);
   c_mod_flag: cover property (module_event != 3'h0 ##1 flags_r.module_event_flag != 3'h0);

endmodule // counter_array

// >>> verif/cpu_model.sv
/*
 * Processor-side bus master model for the counter array core.
 * Assumes an Avalon-MM slave that drops waitrequest for one cycle to answer.
 */
`timescale 1ns/100ps
module cpu_model
   import counter_array_pkg::*;
(
   input  wire logic              core_clk,    // system clock
   input  wire logic [DATA_W-1:0] readdata,    // read data
   input  wire logic              waitrequest, // low when answered
   output logic      [ADDR_W-1:0] address,     // byte address
   output logic                   read,        // read request
   output logic                   write,       // write request
   output logic      [DATA_W-1:0] writedata    // write data
);
   initial begin
      address   = '0;
      read      = 1'b0;
      write     = 1'b0;
      writedata = '0;
   end

   // values seen right after an edge are the ones sampled at it
   task automatic wait_ack();
      do
         @(posedge core_clk);
      while (waitrequest !== 1'b0);
   endtask

   task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      address   <= a;
      writedata <= d;
      write     <= 1'b1;
      wait_ack();
      write     <= 1'b0;
      writedata <= ~d;
      address   <= ~a;
   endtask

   task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge core_clk);
      address <= a;
      read    <= 1'b1;
      wait_ack();
      d = readdata;
      read    <= 1'b0;
      address <= ~a;
   endtask
endmodule // cpu_model

// >>> verif/counter_array_timebase_and_irq_bench.sv
/*
 * Self-checking bench for the counter array core: counter, snapshot,
 * timebases, event flags and interrupt gating.
 * Assumes cpu_model drives the register bus; all other inputs driven here.
 */
`timescale 1ns/100ps
module counter_array_timebase_and_irq_bench import counter_array_pkg::*;;
   logic              core_clk = 1'b0;
   logic              sys_rst  = 1'b1;
   logic [ADDR_W-1:0] address;
   logic              read;
   logic              write;
   logic [DATA_W-1:0] writedata;
   logic [DATA_W-1:0] readdata;
   logic              waitrequest;
   logic              timer0_overflow = 1'b0;
   logic              ext_pin  = 1'b0;
   logic              osc      = 1'b0;
   logic              rtc      = 1'b0;
   logic              cpu_idle = 1'b0;
   logic [2:0]        module_event = 3'h0;
   logic              array_irq_req;
   logic              cpu_irq;
   int                n_fail   = 0;
   int                n_tests  = 0;

   counter_array i_counter_array (.core_clk(core_clk), .sys_rst(sys_rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .timer0_overflow(timer0_overflow), .external_count_input(ext_pin), .ext_osc_div8(osc),
      .rtc_osc_div8(rtc), .cpu_idle(cpu_idle), .module_event(module_event),
      .array_irq_req(array_irq_req), .cpu_irq(cpu_irq));

   cpu_model i_cpu_model (.core_clk(core_clk), .readdata(readdata), .waitrequest(waitrequest),
      .address(address), .read(read), .write(write), .writedata(writedata));

   initial forever #4 core_clk = ~core_clk;

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      i_cpu_model.bus_wr(a, d);
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      i_cpu_model.bus_rd(a, d);
   endtask

   task automatic set_count(input logic [15:0] v);
      wr(OFS_COUNT_HIGH, {24'h0, v[15:8]});
      wr(OFS_COUNT_LOW, {24'h0, v[7:0]});
   endtask

   task automatic rd_count(output logic [15:0] c);
      logic [31:0] l;
      logic [31:0] h;
      rd(OFS_COUNT_LOW, l);
      rd(OFS_COUNT_HIGH, h);
      c = {h[7:0], l[7:0]};
   endtask

   task automatic chk_irq(input logic exp_req, input logic exp_cpu);
      repeat (4) @(posedge core_clk);
      #1;
      check({31'h0, array_irq_req}, {31'h0, exp_req}, "array irq");
      check({31'h0, cpu_irq}, {31'h0, exp_cpu}, "cpu irq");
   endtask

   task automatic pulse(input logic [2:0] tb);
      case (tb)
         TB_TIMER0:  timer0_overflow <= 1'b1;
         TB_EXT_PIN: ext_pin <= 1'b1;
         TB_EXT_OSC: osc <= 1'b1;
         default:    rtc <= 1'b1;
      endcase
      repeat (tb == TB_TIMER0 ? 1 : 4) @(posedge core_clk);
      {timer0_overflow, ext_pin, osc, rtc} <= 4'h0;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic t_reset_values();
      logic [31:0] d;
      check({30'h0, array_irq_req, cpu_irq}, 32'h0, "irq after reset");
      for (int a = 0; a < 64; a += 4) begin
         rd(6'(a), d);
         check(d, (6'(a) == OFS_MODE) ? 32'h10 : 32'h0, "reset value");
      end
      wr(OFS_COUNT_HIGH, 32'h55);
      rd(OFS_COUNT_LOW, d);
      rd(OFS_COUNT_HIGH, d);
      check(d, 32'h0, "count write in watchdog");
      wr(OFS_MODULE0 + 6'h08, 32'h3);
      rd(OFS_MODULE0 + 6'h08, d);
      check(d, 32'h0, "module 2 in watchdog");
      wr(OFS_MODE, 32'h18);
      rd(OFS_MODE, d);
      check(d, 32'h10, "timebase in watchdog");
      wr(OFS_MODE, 32'h0);
      for (int m = 0; m < 3; m++)
         for (int c = 0; c < 7; c++) begin
            wr(OFS_MODULE0 + 6'(m * 4), 32'(c));
            rd(OFS_MODULE0 + 6'(m * 4), d);
            check(d, (c == 6) ? 32'h5 : 32'(c), "module mode");
         end
   endtask

   task automatic t_snapshot();
      logic [15:0] c;
      logic [31:0] d;
      wr(OFS_MODE, 32'h0e);
      set_count(16'h1234);
      repeat (50) @(posedge core_clk);
      rd_count(c);
      check({16'h0, c}, 32'h1234, "count held");
      rd(OFS_COUNT_LOW, d);
      wr(OFS_COUNT_HIGH, 32'h56);
      rd(OFS_COUNT_HIGH, d);
      check(d, 32'h12, "snapshot");
      rd_count(c);
      check({16'h0, c}, 32'h5634, "live high");
   endtask

   task automatic run_tb(input logic [2:0] tb, input logic idle_s, input int lo, input int hi);
      logic [15:0] c;
      logic [31:0] d;
      wr(OFS_MODE, 32'h0e);
      set_count(16'h0);
      wr(OFS_MODE, {26'h0, idle_s, 1'b0, tb, 1'b0});
      if (tb == TB_TIMER0 || tb == TB_EXT_PIN || tb == TB_EXT_OSC || tb == TB_RTC_OSC)
         repeat (5) pulse(tb);
      else
         repeat (32) rd(OFS_COUNT_LOW, d);
      repeat (8) @(posedge core_clk);
      wr(OFS_MODE, 32'h0e);
      rd_count(c);
      check({31'h0, (int'(c) >= lo && int'(c) <= hi)}, 32'h1, "ticks");
   endtask

   task automatic t_timebase();
      run_tb(TB_DIV12, 1'b0, 8, 10);
      run_tb(TB_DIV4, 1'b0, 25, 28);
      run_tb(TB_TIMER0, 1'b0, 5, 5);
      run_tb(TB_EXT_PIN, 1'b0, 5, 5);
      run_tb(TB_EXT_OSC, 1'b0, 5, 5);
      run_tb(TB_RTC_OSC, 1'b0, 5, 5);
      run_tb(3'h7, 1'b0, 0, 0);
      cpu_idle <= 1'b1;
      run_tb(TB_SYSCLK, 1'b0, 102, 110);
      run_tb(TB_SYSCLK, 1'b1, 0, 0);
      cpu_idle <= 1'b0;
      run_tb(TB_SYSCLK, 1'b1, 102, 110);
   endtask

   task automatic t_cycle_len();
      logic [31:0] d;
      for (int cl = 0; cl < 4; cl++)
         for (int k = 0; k < 2; k++) begin
            wr(OFS_ENABLE, 32'(cl << 4));
            wr(OFS_MODE, 32'h0e);
            wr(OFS_FLAGS, 32'h0);
            set_count(k == 1 ? 16'((1 << (8 + cl)) - 4) : 16'h00fc);
            wr(OFS_MODE, 32'h08);
            repeat (4) @(posedge core_clk);
            wr(OFS_MODE, 32'h0e);
            rd(OFS_FLAGS, d);
            check(d & 32'h08, (k == 1 || cl == 0) ? 32'h08 : 32'h0, "intermediate");
         end
   endtask

   task automatic t_overflow_irq();
      logic [31:0] d;
      wr(OFS_ENABLE, 32'h0);
      wr(OFS_FLAGS, 32'h0);
      set_count(16'hfffd);
      wr(OFS_MODE, 32'h08);
      repeat (10) @(posedge core_clk);
      wr(OFS_MODE, 32'h0e);
      rd(OFS_FLAGS, d);
      check(d, 32'h18, "overflow flags");
      chk_irq(1'b0, 1'b0);
      wr(OFS_MODE, 32'h0f);
      for (int g = 0; g < 4; g++) begin
         wr(OFS_GLOBAL, 32'(g));
         chk_irq(1'b1, g == 3);
      end
      repeat (20) @(posedge core_clk);
      rd(OFS_FLAGS, d);
      check(d, 32'h18, "flag kept");
      wr(OFS_MODE, 32'h0e);
      chk_irq(1'b0, 1'b0);
      wr(OFS_ENABLE, 32'h08);
      chk_irq(1'b1, 1'b1);
      wr(OFS_ENABLE, 32'h0);
      wr(OFS_FLAGS, 32'h0);
      rd(OFS_FLAGS, d);
      check(d, 32'h0, "flags cleared");
      for (int n = 0; n < 3; n++) begin
         module_event <= 3'(1 << n);
         @(posedge core_clk);
         module_event <= 3'h0;
         rd(OFS_FLAGS, d);
         check(d, 32'(1 << n), "module flag");
         chk_irq(1'b0, 1'b0);
         wr(OFS_ENABLE, 32'(1 << n));
         chk_irq(1'b1, 1'b1);
         wr(OFS_ENABLE, 32'h0);
         wr(OFS_FLAGS, 32'h0);
      end
   endtask

   initial begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset_values();
      t_snapshot();
      t_timebase();
      t_cycle_len();
      t_overflow_irq();
      stop_test();
   end

   // run needs well under 10000 cycles
   initial begin
      #200000;
      n_fail++;
      $display("wrong value at %0t: run timed out", $time);
      stop_test();
   end
endmodule // counter_array_timebase_and_irq_bench
